// *** sfc_defines.svh ***
// constants of the serial flash command framing host controller
`ifndef SFC_DEFINES_SVH
`define SFC_DEFINES_SVH

`define SFC_OP_READ_LONG       8'h13
`define SFC_OP_FAST_READ_LONG  8'h0c
`define SFC_OP_DUAL_OUT_LONG   8'h3c
`define SFC_OP_QUAD_OUT_LONG   8'h6c
`define SFC_OP_DUAL_IO_LONG    8'hbc
`define SFC_OP_QUAD_IO_LONG    8'hec
`define SFC_OP_PAGE_LONG       8'h12
`define SFC_OP_QUAD_PAGE_LONG  8'h34
`define SFC_OP_SMALL_ERA_LONG  8'h21
`define SFC_OP_LARGE_ERA_LONG  8'hdc
`define SFC_OP_READ            8'h03
`define SFC_OP_FAST_READ       8'h0b
`define SFC_OP_DUAL_OUT        8'h3b
`define SFC_OP_QUAD_OUT        8'h6b
`define SFC_OP_DUAL_IO         8'hbb
`define SFC_OP_QUAD_IO         8'heb
`define SFC_OP_PAGE            8'h02
`define SFC_OP_QUAD_PAGE       8'h32
`define SFC_OP_QUAD_PAGE_ALT   8'h38
`define SFC_OP_SMALL_ERA       8'h20
`define SFC_OP_LARGE_ERA       8'hd8
`define SFC_OP_STATUS_READ     8'h05
`define SFC_OP_BANK_WRITE      8'h17

`define SFC_WIP_BIT            0
`define SFC_EXT_BIT            7
`define SFC_LONG_BYTES         16'd4
`define SFC_SHORT_BYTES        16'd3
`define SFC_LANE1              3'd1
`define SFC_LANE2              3'd2
`define SFC_LANE4              3'd4
`define SFC_SCK_HALF           4'd2
`define SFC_CS_LEAD            4'd2
`define SFC_CS_GAP             4'd4

`endif

// *** sfc_pkg.sv ***
// types and opcode helpers of the serial flash host controller
`default_nettype none
`include "sfc_defines.svh"
package sfc_pkg;

   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,
      ST_SETUP = 4'b0010,
      ST_SHIFT = 4'b0100,
      ST_HOLD  = 4'b1000
   } sfc_state_t;

   typedef enum logic [5:0] {
      PH_INSTR = 6'b000001,
      PH_ADDR  = 6'b000010,
      PH_MODE  = 6'b000100,
      PH_DUMMY = 6'b001000,
      PH_WDATA = 6'b010000,
      PH_RDATA = 6'b100000
   } sfc_phase_t;

   typedef struct packed {
      logic [7:0]  opcode;
      logic [31:0] addr;
      logic        has_addr;
      logic        skip_instr;
      logic        mode_en;
      logic [7:0]  mode;
      logic [7:0]  dummy;
      logic        is_write;
      logic        wait_idle;
      logic [15:0] len;
   } sfc_cmd_t;

   typedef struct packed {
      logic [3:0] cnt;
      logic       sck;
   } sfc_ck_t;

   typedef struct packed {
      logic [3:0] meta;
      logic [3:0] q;
   } sfc_sync_t;

   function automatic logic is_long_op(input logic [7:0] op);
      case (op)
         `SFC_OP_READ_LONG, `SFC_OP_FAST_READ_LONG, `SFC_OP_DUAL_OUT_LONG,
         `SFC_OP_QUAD_OUT_LONG, `SFC_OP_DUAL_IO_LONG, `SFC_OP_QUAD_IO_LONG,
         `SFC_OP_PAGE_LONG, `SFC_OP_QUAD_PAGE_LONG, `SFC_OP_SMALL_ERA_LONG,
         `SFC_OP_LARGE_ERA_LONG: is_long_op = 1'b1;
         default: is_long_op = 1'b0;
      endcase
   endfunction : is_long_op

   function automatic logic is_legacy_op(input logic [7:0] op);
      case (op)
         `SFC_OP_READ, `SFC_OP_FAST_READ, `SFC_OP_DUAL_OUT, `SFC_OP_QUAD_OUT,
         `SFC_OP_DUAL_IO, `SFC_OP_QUAD_IO, `SFC_OP_PAGE, `SFC_OP_QUAD_PAGE,
         `SFC_OP_SMALL_ERA, `SFC_OP_LARGE_ERA: is_legacy_op = 1'b1;
         default: is_legacy_op = 1'b0;
      endcase
   endfunction : is_legacy_op

   function automatic logic [2:0] addr_lanes(input logic [7:0] op);
      case (op)
         `SFC_OP_DUAL_IO, `SFC_OP_DUAL_IO_LONG: addr_lanes = `SFC_LANE2;
         `SFC_OP_QUAD_IO, `SFC_OP_QUAD_IO_LONG: addr_lanes = `SFC_LANE4;
         default: addr_lanes = `SFC_LANE1;
      endcase
   endfunction : addr_lanes

   function automatic logic [2:0] data_lanes(input logic [7:0] op);
      case (op)
         `SFC_OP_DUAL_OUT, `SFC_OP_DUAL_OUT_LONG, `SFC_OP_DUAL_IO,
         `SFC_OP_DUAL_IO_LONG: data_lanes = `SFC_LANE2;
         `SFC_OP_QUAD_OUT, `SFC_OP_QUAD_OUT_LONG, `SFC_OP_QUAD_IO,
         `SFC_OP_QUAD_IO_LONG, `SFC_OP_QUAD_PAGE, `SFC_OP_QUAD_PAGE_ALT,
         `SFC_OP_QUAD_PAGE_LONG: data_lanes = `SFC_LANE4;
         default: data_lanes = `SFC_LANE1;
      endcase
   endfunction : data_lanes

endpackage : sfc_pkg
`default_nettype wire

// *** sfc_clk_gen.sv ***
// serial clock divider with rise and fall strobes
`timescale 1ns/1ps
`default_nettype none
`include "sfc_defines.svh"
module sfc_clk_gen (
   input  wire logic clk,
   input  wire logic sys_rst,
   input  wire logic run,
   output logic      sck,
   output logic      rise_stb,
   output logic      fall_stb
);
   import sfc_pkg::*;

   sfc_ck_t s;
   sfc_ck_t next_s;
   logic    wrap;

   always_comb begin
      next_s   = s;
      wrap     = run && (s.cnt == `SFC_SCK_HALF - 4'd1);
      rise_stb = wrap && !s.sck;
      fall_stb = wrap && s.sck;
      if (run) begin
         next_s.cnt = wrap ? 4'd0 : s.cnt + 4'd1;
         if (wrap) begin
            next_s.sck = !s.sck;
         end
      end else begin
         next_s.cnt = 4'd0;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign sck = s.sck;
endmodule : sfc_clk_gen
`default_nettype wire

// *** sfc_io_sync.sv ***
// two-stage synchroniser for the io pin inputs
`timescale 1ns/1ps
`default_nettype none
module sfc_io_sync (
   input  wire logic       clk,
   input  wire logic       sys_rst,
   input  wire logic [3:0] io_pin,
   output logic      [3:0] io_q
);
   import sfc_pkg::*;

   sfc_sync_t s;
   sfc_sync_t next_s;

   always_comb begin
      next_s.meta = io_pin;
      next_s.q    = s.meta;
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign io_q = s.q;
endmodule : sfc_io_sync
`default_nettype wire

// *** sfc_host.sv ***
// serial flash host controller: command framing over multi-line serial bus
`timescale 1ns/1ps
`default_nettype none
`include "sfc_defines.svh"
module sfc_host (
   input  wire logic             clk,
   input  wire logic             sys_rst,
   input  wire logic             cmd_valid,
   output logic                  cmd_ready,
   input  wire sfc_pkg::sfc_cmd_t cmd,
   input  wire logic             wr_valid,
   output logic                  wr_ready,
   input  wire logic [7:0]       wr_data,
   output logic                  rd_valid,
   output logic      [7:0]       rd_data,
   output logic                  done,
   output logic                  busy,
   output logic                  four_byte_address_enable,
   output logic      [7:0]       bank_address_select,
   output logic                  cs_n,
   output logic                  sck,
   input  wire logic [3:0]       io_in,
   output logic      [3:0]       io_out,
   output logic      [3:0]       io_oe
);
   import sfc_pkg::*;

   typedef struct packed {
      sfc_state_t  st;
      sfc_phase_t  ph;
      sfc_cmd_t    fr;
      sfc_cmd_t    usr;
      logic [7:0]  op;
      logic [7:0]  last_op;
      logic [2:0]  lanes;
      logic [2:0]  bitcnt;
      logic [15:0] bytecnt;
      logic [15:0] addr_bytes;
      logic [31:0] addr_sr;
      logic [7:0]  sr;
      logic        need_wr;
      logic        polling;
      logic [7:0]  bank;
      logic [3:0]  cnt;
      logic        cs_n;
      logic [3:0]  io_out;
      logic [3:0]  io_oe;
      logic [7:0]  rd_data;
      logic        rd_valid;
      logic        done;
   } sfc_host_t;

   localparam sfc_host_t RESET_S = '{st: ST_IDLE, ph: PH_INSTR, cs_n: 1'b1,
                                     default: '0};

   sfc_host_t  s;
   sfc_host_t  next_s;
   logic       rise_stb;
   logic       fall_stb;
   logic [3:0] io_q;
   logic       run;

   function automatic logic [2:0] rank(input sfc_phase_t p);
      case (p)
         PH_INSTR: rank = 3'd0;
         PH_ADDR:  rank = 3'd1;
         PH_MODE:  rank = 3'd2;
         PH_DUMMY: rank = 3'd3;
         default:  rank = 3'd4;
      endcase
   endfunction : rank

   // pick and load the next phase of the frame after phase p
   function automatic sfc_host_t enter_after(input sfc_host_t x,
                                             input sfc_phase_t p);
      sfc_host_t  y;
      logic [2:0] r;
      y        = x;
      r        = rank(p);
      y.bitcnt = 3'd0;
      if (r < 3'd1 && x.fr.has_addr) begin
         y.ph      = PH_ADDR;
         y.lanes   = addr_lanes(x.op);
         y.bytecnt = x.addr_bytes;
         y.sr      = x.addr_sr[31:24];
         y.addr_sr = {x.addr_sr[23:0], 8'h00};
      end else if (r < 3'd2 && x.fr.mode_en) begin
         y.ph      = PH_MODE;
         y.lanes   = addr_lanes(x.op);
         y.bytecnt = 16'd1;
         y.sr      = x.fr.mode;
      end else if (r < 3'd3 && x.fr.dummy != 8'h00) begin
         y.ph      = PH_DUMMY;
         y.lanes   = data_lanes(x.op);
         y.bytecnt = {8'h00, x.fr.dummy};
      end else if (r < 3'd4 && x.fr.len != 16'd0) begin
         y.lanes   = data_lanes(x.op);
         y.bytecnt = x.fr.len;
         if (x.fr.is_write) begin
            y.ph      = PH_WDATA;
            y.need_wr = 1'b1;
         end else begin
            y.ph = PH_RDATA;
            y.sr = 8'h00;
         end
      end else begin
         y.st  = ST_HOLD;
         y.cnt = 4'd0;
      end
      return y;
   endfunction : enter_after

   // open a frame: status poll first when asked, else the user command
   function automatic sfc_host_t start_frame(input sfc_host_t x);
      sfc_host_t y;
      y        = x;
      y.st     = ST_SETUP;
      y.cnt    = 4'd0;
      y.bitcnt = 3'd0;
      if (x.polling) begin
         y.fr          = '0;
         y.fr.opcode   = `SFC_OP_STATUS_READ;
         y.fr.len      = 16'd1;
      end else begin
         y.fr = x.usr;
      end
      y.op = y.fr.skip_instr ? x.last_op : y.fr.opcode;
      if (!x.polling) begin
         y.last_op = y.op;
      end
      if (is_long_op(y.op) ||
          (is_legacy_op(y.op) && x.bank[`SFC_EXT_BIT])) begin
         y.addr_bytes = `SFC_LONG_BYTES;
         y.addr_sr    = y.fr.addr;
      end else begin
         y.addr_bytes = `SFC_SHORT_BYTES;
         y.addr_sr    = {y.fr.addr[23:0], 8'h00};
      end
      if (y.fr.skip_instr) begin
         y = enter_after(y, PH_INSTR);
         y.st = ST_SETUP;
      end else begin
         y.ph      = PH_INSTR;
         y.lanes   = `SFC_LANE1;
         y.bytecnt = 16'd1;
         y.sr      = y.op;
      end
      return y;
   endfunction : start_frame

   sfc_clk_gen u_clk_gen (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .run      (run),
      .sck      (sck),
      .rise_stb (rise_stb),
      .fall_stb (fall_stb)
   );

   sfc_io_sync u_io_sync (
      .clk     (clk),
      .sys_rst (sys_rst),
      .io_pin  (io_in),
      .io_q    (io_q)
   );

   // clock stalls at byte boundary while write data is missing
   assign run       = (s.st == ST_SHIFT) && !s.need_wr;
   assign cmd_ready = (s.st == ST_IDLE);
   assign wr_ready  = (s.st == ST_SHIFT) && s.need_wr;
   assign busy      = (s.st != ST_IDLE);

   always_comb begin
      next_s          = s;
      next_s.rd_valid = 1'b0;
      next_s.done     = 1'b0;
      case (s.st)
         ST_IDLE: begin
            next_s.cs_n = 1'b1;
            if (cmd_valid) begin
               next_s.usr     = cmd;
               next_s.polling = cmd.wait_idle;
               next_s         = start_frame(next_s);
            end
         end
         ST_SETUP: begin
            next_s.cs_n = 1'b0;
            next_s.cnt  = s.cnt + 4'd1;
            if (s.cnt == `SFC_CS_LEAD - 4'd1) begin
               next_s.st = (s.st == ST_SETUP && s.ph == PH_INSTR &&
                            s.bytecnt == 16'd0) ? ST_HOLD : ST_SHIFT;
            end
         end
         ST_SHIFT: begin
            if (s.need_wr && wr_valid) begin
               next_s.sr      = wr_data;
               next_s.need_wr = 1'b0;
               if (s.op == `SFC_OP_BANK_WRITE) begin
                  next_s.bank = wr_data;
               end
            end else if (fall_stb && s.ph == PH_DUMMY) begin
               next_s.bytecnt = s.bytecnt - 16'd1;
               if (s.bytecnt == 16'd1) begin
                  next_s = enter_after(s, PH_DUMMY);
               end
            end else if (fall_stb) begin
               // sample late in the high half to cover sync delay
               case (s.lanes)
                  `SFC_LANE2: next_s.sr = {s.sr[5:0], io_q[1:0]};
                  `SFC_LANE4: next_s.sr = {s.sr[3:0], io_q[3:0]};
                  default:    next_s.sr = {s.sr[6:0], io_q[1]};
               endcase
               next_s.bitcnt = s.bitcnt + 3'd1;
               if ((s.lanes == `SFC_LANE1 && s.bitcnt == 3'd7) ||
                   (s.lanes == `SFC_LANE2 && s.bitcnt == 3'd3) ||
                   (s.lanes == `SFC_LANE4 && s.bitcnt == 3'd1)) begin
                  next_s.bitcnt = 3'd0;
                  if (s.ph == PH_RDATA) begin
                     next_s.rd_data  = next_s.sr;
                     next_s.rd_valid = !s.polling;
                  end
                  if (s.bytecnt == 16'd1) begin
                     next_s = enter_after(next_s, s.ph);
                  end else begin
                     next_s.bytecnt = s.bytecnt - 16'd1;
                     if (s.ph == PH_ADDR) begin
                        next_s.sr      = s.addr_sr[31:24];
                        next_s.addr_sr = {s.addr_sr[23:0], 8'h00};
                     end else if (s.ph == PH_WDATA) begin
                        next_s.need_wr = 1'b1;
                     end
                  end
               end
            end
         end
         ST_HOLD: begin
            next_s.cs_n = 1'b1;
            next_s.cnt  = s.cnt + 4'd1;
            if (s.cnt == `SFC_CS_GAP - 4'd1) begin
               if (s.polling && !s.rd_data[`SFC_WIP_BIT]) begin
                  next_s.polling = 1'b0;
                  next_s         = start_frame(next_s);
               end else if (s.polling) begin
                  next_s = start_frame(s);
               end else begin
                  next_s.st   = ST_IDLE;
                  next_s.done = 1'b1;
               end
            end
         end
         default: begin
            next_s = RESET_S;
         end
      endcase
      // pin drive follows phase and lane width
      next_s.io_out = 4'h0;
      next_s.io_oe  = 4'h0;
      if (next_s.st == ST_SETUP || next_s.st == ST_SHIFT) begin
         case (next_s.lanes)
            `SFC_LANE2: next_s.io_out = {2'b00, next_s.sr[7:6]};
            `SFC_LANE4: next_s.io_out = next_s.sr[7:4];
            default:    next_s.io_out = {3'b000, next_s.sr[7]};
         endcase
         if (next_s.lanes == `SFC_LANE1) begin
            next_s.io_oe = 4'h1;
         end else if (next_s.ph == PH_RDATA || next_s.ph == PH_DUMMY) begin
            next_s.io_oe = 4'h0;
         end else if (next_s.lanes == `SFC_LANE2) begin
            next_s.io_oe = 4'h3;
         end else begin
            next_s.io_oe = 4'hf;
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         s <= RESET_S;
      end else begin
         s <= next_s;
      end
   end

   assign cs_n                     = s.cs_n;
   assign io_out                   = s.io_out;
   assign io_oe                    = s.io_oe;
   assign rd_valid                 = s.rd_valid;
   assign rd_data                  = s.rd_data;
   assign done                     = s.done;
   assign bank_address_select      = s.bank;
   assign four_byte_address_enable = s.bank[`SFC_EXT_BIT];
endmodule : sfc_host
`default_nettype wire

// *** sfc_host_checker.sv ***
// assertion checker of the serial flash host controller ports
`timescale 1ns/1ps
`default_nettype none
module sfc_host_checker (
   input wire logic       clk,
   input wire logic       sys_rst,
   input wire logic       cmd_valid,
   input wire logic       cmd_ready,
   input wire logic       rd_valid,
   input wire logic       done,
   input wire logic       busy,
   input wire logic       four_byte_address_enable,
   input wire logic [7:0] bank_address_select,
   input wire logic       cs_n,
   input wire logic       sck,
   input wire logic [3:0] io_out,
   input wire logic [3:0] io_oe
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);

   sequence s_sck_high;
      sck [*2] ##1 !sck;
   endsequence
   sequence s_gap_seen;
      $past(cs_n, 1) && $past(cs_n, 2) && $past(cs_n, 3);
   endsequence

   a_ready_busy: assert property (cmd_ready != busy)
      else $error("ready and busy agree");
   a_start_select: assert property (cmd_valid && cmd_ready |-> ##[1:3] !cs_n)
      else $error("select not lowered after accept");
   a_select_lead: assert property ($rose(sck) |-> !cs_n && !$past(cs_n))
      else $error("clock rose without select lead");
   a_clock_idle: assert property (cs_n |-> !sck)
      else $error("clock not idle low");
   a_clock_half: assert property ($rose(sck) |-> s_sck_high)
      else $error("clock high time wrong");
   a_io_on_fall: assert property (!cs_n && !$past(cs_n) && $changed(io_out) |-> !sck)
      else $error("io changed while clock high");
   a_idle_release: assert property (!busy |-> cs_n && io_oe == 4'h0)
      else $error("pins driven while idle");
   a_done_gap: assert property (done |-> s_gap_seen)
      else $error("done without select gap");
   a_done_pulse: assert property (done |=> !done)
      else $error("done longer than one cycle");
   a_ext_mirror: assert property (four_byte_address_enable == bank_address_select[7])
      else $error("extended bit differs from bank bit");
   a_read_busy: assert property (rd_valid |-> busy && !done)
      else $error("read byte outside a command");
endmodule : sfc_host_checker

bind sfc_host sfc_host_checker u_chk (.clk(clk), .sys_rst(sys_rst),
   .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .rd_valid(rd_valid),
   .done(done), .busy(busy),
   .four_byte_address_enable(four_byte_address_enable),
   .bank_address_select(bank_address_select), .cs_n(cs_n), .sck(sck),
   .io_out(io_out), .io_oe(io_oe));
`default_nettype wire

// *** sfc_flash_model.sv ***
// behavioural serial flash device facing the host controller
`timescale 1ns/1ps
`default_nettype none
module sfc_flash_model #(
   parameter int DUMMY = 4
) (
   input  wire logic       cs_n,
   input  wire logic       sck,
   input  wire logic [3:0] io_out,
   input  wire logic [3:0] io_oe,
   output logic      [3:0] io_in
);
   logic [3:0]  d_out     = 4'h0;
   logic [3:0]  d_oe      = 4'h0;
   logic [7:0]  bank      = 8'h00;
   logic        cont      = 1'b0;
   logic [7:0]  op        = 8'h00;
   logic [31:0] last_addr = 32'h0;
   logic [7:0]  wbytes[$];
   logic [7:0]  pend[$];
   int          got       = 0;
   int          write_in_progress       = 0;

   // released lanes show the inverse of the last value
   always_comb
      for (int i = 0; i < 4; i++)
         io_in[i] = io_oe[i] ? io_out[i] : d_oe[i] ? d_out[i] : ~d_out[i];

   function automatic logic [7:0] pattern(input logic [31:0] a);
      return a[7:0] ^ a[15:8] ^ a[31:24] ^ 8'h3c;
   endfunction : pattern

   task automatic rx(input int ln, input int n, output logic [31:0] v);
      v = 32'h0;
      for (int i = 0; i < n; i += ln) begin
         @(posedge sck);
         got += ln;
         v = (v << ln) | 32'(io_in & 4'((1 << ln) - 1));
      end
   endtask : rx

   task automatic tx(input int ln, input logic [7:0] b);
      for (int i = 8 - ln; i >= 0; i -= ln) begin
         @(negedge sck);
         d_oe = ln == 1 ? 4'h2 : 4'((1 << ln) - 1);
         d_out = ln == 1 ? {2'b00, b[i], 1'b0} : 4'(b >> i);
      end
   endtask : tx

   task automatic frame();
      logic [31:0] v;
      logic [31:0] a;
      logic        lng;
      int          ln;
      int          dl;
      if (!cont) begin
         rx(1, 8, v);
         op = v[7:0];
      end
      cont = 1'b0;
      ln = op inside {8'hbb, 8'hbc} ? 2 : op inside {8'heb, 8'hec} ? 4 : 1;
      dl = op inside {8'h3b, 8'h3c} ? 2 : ln;
      if (op inside {8'h6b, 8'h6c, 8'h32, 8'h34, 8'h38}) dl = 4;
      lng = op inside {8'h13, 8'h0c, 8'h3c, 8'h6c, 8'hbc, 8'hec, 8'h12,
                       8'h34, 8'h21, 8'hdc} || bank[7];
      if (op == 8'h05)
         forever begin
            tx(1, {7'h00, write_in_progress != 0});
            if (write_in_progress > 0) write_in_progress--;
         end
      if (op == 8'h17) begin
         rx(1, 8, v);
         bank = v[7:0];
      end else begin
         rx(ln, lng ? 32 : 24, v);
         a = lng ? v : {bank, v[23:0]};
         last_addr = a;
         if (ln > 1) begin
            rx(ln, 8, v);
            cont = v[7:4] == 4'ha;
         end
         if (op inside {8'h20, 8'h21, 8'hd8, 8'hdc}) write_in_progress = 3;
         if (op inside {8'h02, 8'h12, 8'h32, 8'h34, 8'h38})
            forever begin
               rx(dl, 8, v);
               pend.push_back(v[7:0]);
               write_in_progress = 3;
            end
         repeat (op inside {8'h03, 8'h13} ? 0 : DUMMY) @(posedge sck);
         if (write_in_progress != 0) forever @(posedge sck);
         forever begin
            tx(dl, pattern(a));
            a++;
         end
      end
   endtask : frame

   initial
      forever begin
         @(negedge cs_n);
         fork
            frame();
            @(posedge cs_n);
         join_any
         disable fork;
         if (got % 8 == 0) wbytes = {wbytes, pend};
         pend.delete();
         got = 0;
         d_oe = 4'h0;
      end
endmodule : sfc_flash_model
`default_nettype wire

// *** testbench.sv ***
// self-checking bench of the serial flash host controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b, m) begin compares++; if ((a) !== (b)) begin fails++; \
   $display("mismatch %0t %s", $time, m); end end
module testbench;
   import sfc_pkg::*;
   localparam int DUM = 4;
   logic        clk       = 1'b0;
   logic        sys_rst   = 1'b1;
   logic        cmd_valid = 1'b0;
   sfc_cmd_t    cmd       = '0;
   logic        wr_valid  = 1'b0;
   logic [7:0]  wr_data   = 8'h00;
   logic        cmd_ready, wr_ready, rd_valid, done, busy, ext, cs_n, sck;
   logic [7:0]  rd_data, bank;
   logic [3:0]  io_in, io_out, io_oe;
   logic [7:0]  eq[$], wq[$], wexp[$];
   logic [31:0] lf        = 32'h00011c16;
   logic [31:0] a;
   int          fails     = 0;
   int          compares  = 0;
   logic [7:0]  leg[6]    = '{8'h03, 8'h0b, 8'h3b, 8'h6b, 8'hbb, 8'heb};
   logic [7:0]  lng[6]    = '{8'h13, 8'h0c, 8'h3c, 8'h6c, 8'hbc, 8'hec};

   always #12.5 clk = ~clk;

   sfc_host dut (.clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
      .cmd_ready(cmd_ready), .cmd(cmd), .wr_valid(wr_valid),
      .wr_ready(wr_ready), .wr_data(wr_data), .rd_valid(rd_valid),
      .rd_data(rd_data), .done(done), .busy(busy),
      .four_byte_address_enable(ext), .bank_address_select(bank),
      .cs_n(cs_n), .sck(sck), .io_in(io_in), .io_out(io_out), .io_oe(io_oe));
   sfc_flash_model #(.DUMMY(DUM)) fm (.cs_n(cs_n), .sck(sck),
      .io_out(io_out), .io_oe(io_oe), .io_in(io_in));

   function automatic logic [7:0] dat(input logic [31:0] x);
      return x[7:0] ^ x[15:8] ^ x[31:24] ^ 8'h3c;
   endfunction : dat

   function automatic logic [31:0] rnd();
      lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
      return lf;
   endfunction : rnd

   task automatic test_done();
      if (fails == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : test_done

   task automatic run(input logic [7:0] op, input logic [31:0] ad,
      input logic sk, input logic [7:0] md, input logic wt, input int n,
      input logic [31:0] ea);
      sfc_cmd_t   c;
      logic [7:0] d;
      int         i;
      c = '0;
      c.opcode = op;
      c.addr = ad;
      c.skip_instr = sk;
      c.mode = md;
      c.wait_idle = wt;
      c.len = 16'(n);
      c.has_addr = op != 8'h17;
      c.mode_en = op inside {8'hbb, 8'hbc, 8'heb, 8'hec};
      c.is_write = op inside {8'h02, 8'h32, 8'h17};
      c.dummy = op inside {8'h03, 8'h13, 8'hd8, 8'h21} || c.is_write ?
                8'h00 : 8'(DUM);
      for (i = 0; i < n; i++)
         if (!c.is_write)
            eq.push_back(dat(ea + 32'(i)));
         else begin
            d = op == 8'h17 ? ad[7:0] : 8'(rnd());
            wq.push_back(d);
            if (op != 8'h17) wexp.push_back(d);
         end
      @(negedge clk);
      while (cmd_ready !== 1'b1) @(negedge clk);
      @(posedge clk);
      cmd <= c;
      cmd_valid <= 1'b1;
      @(posedge clk);
      cmd_valid <= 1'b0;
      i = 0;
      do begin
         @(negedge clk);
         i++;
      end while (done !== 1'b1 && i < 20000);
      `CHK(i < 20000, 1'b1, "command never finished")
   endtask : run

   always @(posedge clk) begin
      if (wr_valid === 1'b1 && wr_ready === 1'b1)
         wq.delete(0);
      wr_valid <= wq.size() > 0;
      wr_data <= wq.size() > 0 ? wq[0] : 8'(lf);
   end

   always @(posedge clk)
      if (rd_valid === 1'b1) begin
         if (eq.size() == 0)
            `CHK(1'b1, 1'b0, "read byte not expected")
         else
            `CHK(rd_data, eq.pop_front(), "read byte")
      end

   initial begin
      #2000000;
      fails++;
      test_done();
   end

   initial begin
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      `CHK(bank, 8'h00, "bank after reset")
      `CHK(ext, 1'b0, "extended bit after reset")
      run(8'h17, 32'h2, 0, 8'h00, 0, 1, 0);
      `CHK(bank, 8'h02, "bank value")
      `CHK(ext, 1'b0, "three byte mode")
      foreach (leg[i]) begin
         a = rnd();
         run(leg[i], a, 0, 8'h00, 0, 3, {8'h02, a[23:0]});
      end
      foreach (lng[i]) begin
         a = rnd();
         run(lng[i], a, 0, 8'h00, 0, 3, a);
      end
      a = rnd();
      run(8'heb, a, 0, 8'ha0, 0, 2, {8'h02, a[23:0]});
      a = rnd();
      run(8'heb, a, 1, 8'h00, 0, 2, {8'h02, a[23:0]});
      run(8'h17, 32'h80, 0, 8'h00, 0, 1, 0);
      `CHK(ext, 1'b1, "four byte mode")
      a = rnd();
      run(8'h03, a, 0, 8'h00, 0, 3, a);
      run(8'h17, 32'h0, 0, 8'h00, 0, 1, 0);
      run(8'h13, 32'h00fffffe, 0, 8'h00, 0, 4, 32'h00fffffe);
      `CHK(bank, 8'h00, "bank kept after read")
      a = rnd();
      run(8'h02, a, 0, 8'h00, 1, 4, 0);
      `CHK(fm.last_addr, {8'h00, a[23:0]}, "program address")
      run(8'h32, a, 0, 8'h00, 1, 4, 0);
      `CHK(fm.wbytes.size(), 8, "written count")
      foreach (wexp[i])
         `CHK(fm.wbytes[i], wexp[i], "written byte")
      run(8'hd8, a, 0, 8'h00, 1, 0, 0);
      a = rnd();
      run(8'h21, a, 0, 8'h00, 1, 0, 0);
      `CHK(fm.last_addr, a, "long erase address")
      run(8'h03, a, 0, 8'h00, 1, 2, {8'h00, a[23:0]});
      repeat (4) @(negedge clk);
      `CHK(eq.size(), 0, "read bytes missing")
      test_done();
   end
endmodule : testbench
`default_nettype wire
